// [rtl/apcp_pkg.sv]
// Constants and types shared by both ends of the configuration load port
package apcp_pkg;
	// Configuration mode codes, latched when init rises
	localparam logic [2:0] APCP_MODE_ASYNC_PERIPH = 3'h5;
	localparam logic [2:0] APCP_MODE_SLAVE_PAR    = 3'h7;
	localparam logic [2:0] APCP_MODE_MASTER_PAR   = 3'h4;
	localparam logic [2:0] APCP_MODE_MPI          = 3'h3;
	// Default timing counts in clock cycles, default byte total and zero byte
	localparam int APCP_STAB_CYCLES  = 16;
	localparam int APCP_CLEAR_CYCLES = 32;
	localparam int APCP_BYTE_CYCLES  = 4;
	localparam int APCP_RCLK_DIV     = 4;
	localparam int APCP_NUM_BYTES    = 64;
	localparam logic [7:0] APCP_BYTE_ZERO = 8'h00;
	// Device configuration states
	typedef enum logic [2:0] {
		APCP_POWER,
		APCP_CLEAR,
		APCP_WAIT,
		APCP_LOAD,
		APCP_DONE
	} apcp_state_t;
	// Host sequencer states
	typedef enum logic [2:0] {
		APCP_H_IDLE,
		APCP_H_WAIT_INIT,
		APCP_H_POLL,
		APCP_H_CHECK,
		APCP_H_WRITE,
		APCP_H_GAP
	} apcp_hstate_t;
endpackage

// [rtl/apcp_if.sv]
// Pin bundle between the host and the configuration load port
`timescale 1ns/1ns
`default_nettype none
interface apcp_if;
	logic       chip_select_active_low;
	logic       chip_select_active_high;
	logic       wr_n;
	logic       rd_n;
	logic [7:0] host_d;
	logic       host_d_oe;
	logic [7:0] dev_d;
	logic       dev_d_oe;
	logic       ready;
	logic       config_busy_high;
	logic       config_busy_low;
	logic       dev_init_oe;
	logic       host_init_oe;
	logic       init_n;
	logic       tck;
	logic       tms;
	// Open-drain init line with pull-up
	assign init_n = ~(dev_init_oe | host_init_oe);
	modport device (
		input  chip_select_active_low, chip_select_active_high, wr_n, rd_n, host_d,
		input  init_n, tck, tms,
		output dev_d, dev_d_oe, ready, config_busy_high, config_busy_low, dev_init_oe
	);
	modport host (
		output chip_select_active_low, chip_select_active_high, wr_n, rd_n, host_d,
		output host_d_oe, host_init_oe, tck, tms,
		input  dev_d, dev_d_oe, ready, config_busy_high, config_busy_low, init_n
	);
endinterface
`default_nettype wire

// [rtl/apcp_device.sv]
// Device end of the configuration load port
`timescale 1ns/1ns
`default_nettype none
module apcp_device
	import apcp_pkg::*;
#(
	parameter int STAB_CYCLES  = APCP_STAB_CYCLES,
	parameter int CLEAR_CYCLES = APCP_CLEAR_CYCLES,
	parameter int BYTE_CYCLES  = APCP_BYTE_CYCLES,
	parameter int RCLK_DIV     = APCP_RCLK_DIV,
	parameter int NUM_BYTES    = APCP_NUM_BYTES
) (
	input  wire logic sys_clk_i,
	input  wire logic rst_n_i,
	input  wire logic [2:0] mode_i,
	input  wire logic scan_select_i,
	apcp_if.device    pins,
	output logic [7:0] byte_o,
	output logic       byte_valid_o,
	output logic       scan_enable_o,
	output logic       config_done_o
);
	// Counts must fit the 16-bit counters and last at least one cycle
	if (STAB_CYCLES < 1 || STAB_CYCLES > 65536) begin : g_bad_stab
		$error("apcp_device: STAB_CYCLES out of range");
	end
	if (CLEAR_CYCLES < 1 || CLEAR_CYCLES > 65536) begin : g_bad_clear
		$error("apcp_device: CLEAR_CYCLES out of range");
	end
	if (BYTE_CYCLES < 1 || BYTE_CYCLES > 65536) begin : g_bad_byte
		$error("apcp_device: BYTE_CYCLES out of range");
	end
	// Read clock needs an even divide of at least two
	if (RCLK_DIV < 2 || RCLK_DIV > 65536 || RCLK_DIV % 2 != 0) begin : g_bad_rclk
		$error("apcp_device: RCLK_DIV out of range");
	end
	// Byte total is compared against a 16-bit counter
	if (NUM_BYTES < 1 || NUM_BYTES > 65535) begin : g_bad_bytes
		$error("apcp_device: NUM_BYTES out of range");
	end

	apcp_state_t state_q;
	logic [15:0] cnt_q;
	logic [15:0] nbytes_q;
	logic [15:0] byte_cnt_q;
	logic [2:0]  mode_q;
	logic        selected;
	logic        wr_act;
	logic        rd_act;
	logic        wr_take;
	logic        wr_prev_q;
	logic        busy_q;
	logic        rclk_q;
	logic [15:0] rdiv_q;

	// Select decode and strobe qualification
	assign selected = ~pins.chip_select_active_low & pins.chip_select_active_high;
	assign wr_act = selected && !pins.wr_n && mode_q != APCP_MODE_MASTER_PAR;
	assign rd_act = selected && !pins.rd_n && pins.wr_n;

	// Configuration sequence
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state_q <= APCP_POWER;
			cnt_q   <= 16'h0000;
		end else begin
			unique case (state_q)
				APCP_POWER: begin
					if (cnt_q == 16'(STAB_CYCLES - 1)) begin
						state_q <= APCP_CLEAR;
						cnt_q   <= 16'h0000;
					end else begin
						cnt_q <= cnt_q + 16'h0001;
					end
				end
				APCP_CLEAR: begin
					if (cnt_q == 16'(CLEAR_CYCLES - 1)) begin
						state_q <= APCP_WAIT;
						cnt_q   <= 16'h0000;
					end else begin
						cnt_q <= cnt_q + 16'h0001;
					end
				end
				APCP_WAIT: begin
					if (pins.init_n) begin
						state_q <= APCP_LOAD;
					end
				end
				APCP_LOAD: begin
					if (nbytes_q == 16'(NUM_BYTES)) begin
						state_q <= APCP_DONE;
					end
				end
				APCP_DONE: begin
					state_q <= APCP_DONE;
				end
			endcase
		end
	end

	// Mode latched as init rises
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			mode_q <= APCP_MODE_ASYNC_PERIPH;
		end else if (state_q == APCP_WAIT && pins.init_n) begin
			mode_q <= mode_i;
		end
	end

	// Init pulled low during stabilisation and clearing
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			pins.dev_init_oe <= 1'b1;
		end else begin
			pins.dev_init_oe <= (state_q == APCP_POWER) ||
				(state_q == APCP_CLEAR && cnt_q != 16'(CLEAR_CYCLES - 1));
		end
	end

	// Byte taken as the selected write strobe first goes low, loading and idle
	assign wr_take = state_q == APCP_LOAD && wr_act && !wr_prev_q && !busy_q;

	// Write strobe history for edge detection
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			wr_prev_q <= 1'b0;
		end else begin
			wr_prev_q <= wr_act;
		end
	end

	// Captured byte and its one-cycle valid pulse
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			byte_o       <= APCP_BYTE_ZERO;
			byte_valid_o <= 1'b0;
		end else begin
			byte_valid_o <= wr_take;
			if (wr_take) begin
				byte_o <= pins.host_d;
			end
		end
	end

	// Count of bytes taken, ends loading
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			nbytes_q <= 16'h0000;
		end else if (wr_take) begin
			nbytes_q <= nbytes_q + 16'h0001;
		end
	end

	// Busy window after each byte; writes inside it are dropped
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			busy_q     <= 1'b0;
			byte_cnt_q <= 16'h0000;
		end else if (wr_take) begin
			busy_q     <= 1'b1;
			byte_cnt_q <= 16'h0000;
		end else if (busy_q) begin
			if (byte_cnt_q == 16'(BYTE_CYCLES - 1)) begin
				busy_q <= 1'b0;
			end
			byte_cnt_q <= byte_cnt_q + 16'h0001;
		end
	end

	// Read clock divider for master parallel mode
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rdiv_q <= 16'h0000;
			rclk_q <= 1'b0;
		end else if (state_q == APCP_LOAD && mode_q == APCP_MODE_MASTER_PAR) begin
			if (rdiv_q == 16'(RCLK_DIV / 2 - 1)) begin
				rdiv_q <= 16'h0000;
				rclk_q <= ~rclk_q;
			end else begin
				rdiv_q <= rdiv_q + 16'h0001;
			end
		end else begin
			rdiv_q <= 16'h0000;
			rclk_q <= 1'b0;
		end
	end

	// Ready pin: read clock in master parallel mode, byte ready otherwise
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			pins.ready <= 1'b0;
		end else if (mode_q == APCP_MODE_MASTER_PAR) begin
			pins.ready <= rclk_q;
		end else begin
			pins.ready <= state_q == APCP_LOAD && !busy_q && !wr_act;
		end
	end

	// Status byte on a selected read in asynchronous peripheral mode only, bit 7 mirrors readiness
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			pins.dev_d    <= APCP_BYTE_ZERO;
			pins.dev_d_oe <= 1'b0;
		end else begin
			pins.dev_d    <= {state_q == APCP_LOAD && !busy_q, 7'h00};
			pins.dev_d_oe <= rd_act && mode_q == APCP_MODE_ASYNC_PERIPH;
		end
	end

	// Progress outputs, all three flip as loading ends
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			pins.config_busy_high <= 1'b1;
			pins.config_busy_low  <= 1'b0;
			config_done_o         <= 1'b0;
		end else begin
			pins.config_busy_high <= state_q != APCP_DONE;
			pins.config_busy_low  <= state_q == APCP_DONE;
			config_done_o         <= state_q == APCP_DONE;
		end
	end

	// Scan stays on during configuration or when chosen
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			scan_enable_o <= 1'b1;
		end else begin
			scan_enable_o <= (state_q != APCP_DONE) || scan_select_i;
		end
	end
endmodule
`default_nettype wire

// [rtl/apcp_host.sv]
// Host end: writes configuration bytes in asynchronous peripheral mode
`timescale 1ns/1ns
`default_nettype none
module apcp_host
	import apcp_pkg::*;
(
	input  wire logic       sys_clk_i,
	input  wire logic       rst_n_i,
	input  wire logic       hold_init_i,
	input  wire logic       use_status_read_i,
	input  wire logic [7:0] byte_i,
	input  wire logic       byte_valid_i,
	output logic            byte_ready_o,
	output logic            done_o,
	apcp_if.host            pins
);
	apcp_hstate_t st_q;

	// Test pins held high throughout
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			pins.tck <= 1'b1;
			pins.tms <= 1'b1;
		end else begin
			pins.tck <= 1'b1;
			pins.tms <= 1'b1;
		end
	end

	// Write sequencer
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			st_q                         <= APCP_H_IDLE;
			pins.chip_select_active_low  <= 1'b1;
			pins.chip_select_active_high <= 1'b0;
			pins.wr_n                    <= 1'b1;
			pins.rd_n                    <= 1'b1;
			pins.host_d                  <= APCP_BYTE_ZERO;
			pins.host_d_oe               <= 1'b0;
			pins.host_init_oe            <= 1'b0;
			byte_ready_o                 <= 1'b0;
			done_o                       <= 1'b0;
		end else begin
			pins.host_init_oe <= hold_init_i;
			done_o            <= ~pins.config_busy_high;
			byte_ready_o      <= 1'b0;
			unique case (st_q)
				APCP_H_IDLE: begin
					st_q <= APCP_H_WAIT_INIT;
				end
				APCP_H_WAIT_INIT: begin
					if (pins.init_n) begin
						st_q                         <= APCP_H_POLL;
						pins.chip_select_active_low  <= 1'b0;
						pins.chip_select_active_high <= 1'b1;
					end
				end
				APCP_H_POLL: begin
					pins.rd_n <= ~use_status_read_i;
					st_q      <= APCP_H_CHECK;
				end
				APCP_H_CHECK: begin
					if (byte_valid_i && ((use_status_read_i && pins.dev_d_oe && pins.dev_d[7])
					    || (!use_status_read_i && pins.ready))) begin
						pins.rd_n      <= 1'b1;
						pins.host_d    <= byte_i;
						pins.host_d_oe <= 1'b1;
						pins.wr_n      <= 1'b0;
						byte_ready_o   <= 1'b1;
						st_q           <= APCP_H_WRITE;
					end
				end
				APCP_H_WRITE: begin
					pins.wr_n <= 1'b1;
					st_q      <= APCP_H_GAP;
				end
				APCP_H_GAP: begin
					pins.host_d_oe <= 1'b0;
					st_q           <= APCP_H_POLL;
				end
				default: begin
					st_q <= APCP_H_IDLE;
				end
			endcase
		end
	end
endmodule
`default_nettype wire

// [tb/apcp_monitor.sv]
// Pin-level checks on the link between host and device ends
`timescale 1ns/1ns
`default_nettype none
module apcp_monitor (
	input wire logic       sys_clk_i,
	input wire logic       rst_n_i,
	input wire logic       chip_select_active_low,
	input wire logic       chip_select_active_high,
	input wire logic       wr_n,
	input wire logic       rd_n,
	input wire logic [7:0] dev_d,
	input wire logic       dev_d_oe,
	input wire logic       ready,
	input wire logic       config_busy_high,
	input wire logic       config_busy_low,
	input wire logic       init_n,
	input wire logic       tck,
	input wire logic       tms
);
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (!rst_n_i);
	// Device selected by both chip selects
	wire logic sel = !chip_select_active_low && chip_select_active_high;
	// Selected read with no write alongside, before configuration is done
	sequence s_rd;
		sel && !rd_n && wr_n && config_busy_high;
	endsequence
	// Start of a write while ready
	sequence s_wr_start;
		sel && $fell(wr_n) && ready && config_busy_high;
	endsequence
	property p_rd_status;
		s_rd ##1 s_rd |-> dev_d_oe;
	endproperty
	property p_rd_bit;
		dev_d_oe && $stable(ready) |-> dev_d[7] == ready;
	endproperty
	property p_wr_wins;
		dev_d_oe |-> $past(wr_n);
	endproperty
	property p_wr_busy;
		s_wr_start |-> ##[1:2] !ready;
	endproperty
	property p_ready_back;
		$fell(ready) |-> ##[1:8] (ready || !config_busy_high);
	endproperty
	property p_wr_after_ready;
		$fell(wr_n) |-> $past(ready);
	endproperty
	property p_busy_pair;
		config_busy_high != config_busy_low;
	endproperty
	property p_init_wait;
		!init_n |-> config_busy_high && wr_n;
	endproperty
	property p_test_pins;
		config_busy_high |-> (tck || tms);
	endproperty
	a_rd_status: assert property (p_rd_status) else $error("no status drive");
	a_rd_bit: assert property (p_rd_bit) else $error("status bit wrong");
	a_wr_wins: assert property (p_wr_wins) else $error("read acted on");
	a_wr_busy: assert property (p_wr_busy) else $error("ready kept");
	a_ready_back: assert property (p_ready_back) else $error("ready late");
	a_wr_after_ready: assert property (p_wr_after_ready) else $error("early write");
	a_busy_pair: assert property (p_busy_pair) else $error("busy pair");
	a_init_wait: assert property (p_init_wait) else $error("left wait");
	a_test_pins: assert property (p_test_pins) else $error("test pins low");
endmodule
`default_nettype wire

// [tb/tb_top.sv]
// Self-checking testbench for both ends of the configuration load port
`timescale 1ns/1ns
`default_nettype none
module tb_top;
	import apcp_pkg::*;
	localparam int NB = 8;
	localparam int T_INIT = APCP_STAB_CYCLES + APCP_CLEAR_CYCLES;
	logic       sys_clk_i, rst_n_i, rst2_n, hold_init, use_rd, byte_vld, scan_sel;
	logic       byte_rdy, hdone, dvld, dvld2, scan_en, cdone;
	logic [7:0] byte_in, dbyte, dbyte2;
	logic [2:0] mode2;
	int         n_fail = 0, checks = 0, n_got = 0, n2 = 0;
	apcp_if lnk ();
	apcp_if lnk2 ();
	// Fault interface: test pins and init pull-up left passive
	assign lnk2.tck = 1'b1;
	assign lnk2.tms = 1'b1;
	assign lnk2.host_init_oe = 1'b0;
	assign lnk2.chip_select_active_high = 1'b1;
	apcp_host apcp_host_i (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .hold_init_i(hold_init),
		.use_status_read_i(use_rd), .byte_i(byte_in), .byte_valid_i(byte_vld),
		.byte_ready_o(byte_rdy), .done_o(hdone), .pins(lnk.host));
	apcp_device #(.NUM_BYTES(NB)) apcp_device_i (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
		.mode_i(APCP_MODE_ASYNC_PERIPH), .scan_select_i(scan_sel), .pins(lnk.device),
		.byte_o(dbyte), .byte_valid_o(dvld), .scan_enable_o(scan_en), .config_done_o(cdone));
	apcp_device #(.NUM_BYTES(NB)) apcp_device_i2 (.sys_clk_i(sys_clk_i), .rst_n_i(rst2_n),
		.mode_i(mode2), .scan_select_i(scan_sel), .pins(lnk2.device), .byte_o(dbyte2),
		.byte_valid_o(dvld2), .scan_enable_o(), .config_done_o());
	apcp_monitor apcp_monitor_i (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
		.chip_select_active_low(lnk.chip_select_active_low), .wr_n(lnk.wr_n),
		.chip_select_active_high(lnk.chip_select_active_high), .rd_n(lnk.rd_n),
		.dev_d(lnk.dev_d), .dev_d_oe(lnk.dev_d_oe), .ready(lnk.ready), .init_n(lnk.init_n),
		.config_busy_high(lnk.config_busy_high), .config_busy_low(lnk.config_busy_low),
		.tck(lnk.tck), .tms(lnk.tms));
	// Clock
	initial begin
		sys_clk_i = 1'b0;
		forever #5 sys_clk_i = ~sys_clk_i;
	end
	// Watchdog
	initial begin
		#100000;
		n_fail++;
		end_of_test();
	end
	// Compare captured bytes with the offered sequence
	always @(negedge sys_clk_i) begin
		if (dvld === 1'b1) begin
			chk_byte(dbyte, 8'ha5 ^ 8'(n_got), "byte");
			n_got++;
		end
		if (dvld2 === 1'b1) begin
			n2++;
		end
	end
	task automatic cyc(input int n);
		repeat (n) @(posedge sys_clk_i);
		#1;
	endtask
	task automatic chk_bit(input logic got, input logic exp, input string what);
		checks++;
		if (got !== exp) begin
			n_fail++;
			$display("mismatch at %0t: %s got %b", $time, what, got);
		end
	endtask
	task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp, input string what);
		checks++;
		if (got !== exp) begin
			n_fail++;
			$display("mismatch at %0t: %s got %h want %h", $time, what, got, exp);
		end
	endtask
	task automatic end_of_test();
		$display("checks %0d n_fail %0d", checks, n_fail);
		if (n_fail == 0 && checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	// Host holds init low well past clearing, then lets go
	task automatic t_init_hold();
		cyc(T_INIT + 20);
		chk_bit(lnk.init_n, 1'b0, "init held");
		chk_bit(lnk.config_busy_high, 1'b1, "busy high");
		chk_bit(lnk.config_busy_low, 1'b0, "busy low");
		chk_bit(scan_en, 1'b1, "scan during config");
		chk_byte(8'(n_got), 8'h00, "no load in wait");
		hold_init = 1'b0;
		cyc(4);
		chk_bit(lnk.init_n, 1'b1, "init free");
	endtask
	// Back-to-back bytes, polling pin and bit 7 in turn
	task automatic t_load();
		byte_vld = 1'b1;
		for (int k = 0; k < NB; k++) begin
			use_rd = k[0];
			byte_in = 8'ha5 ^ 8'(k);
			for (int w = 0; w < 60 && byte_rdy !== 1'b1; w++) cyc(1);
			chk_bit(byte_rdy, 1'b1, "byte taken");
			cyc(1);
		end
		byte_vld = 1'b0;
		for (int w = 0; w < 100 && cdone !== 1'b1; w++) cyc(1);
		cyc(2);
		chk_byte(8'(n_got), 8'(NB), "byte count");
		chk_bit(lnk.config_busy_high, 1'b0, "busy high off");
		chk_bit(lnk.config_busy_low, 1'b1, "busy low off");
		chk_bit(hdone, 1'b1, "host done");
		chk_bit(scan_en, 1'b0, "scan off");
		scan_sel = 1'b1;
		cyc(2);
		chk_bit(scan_en, 1'b1, "scan chosen");
	endtask
	// One write on the fault interface, read strobe as given
	task automatic wr2(input logic csl, input logic [7:0] d, input logic rdl);
		lnk2.chip_select_active_low = csl;
		lnk2.host_d = d;
		lnk2.wr_n = 1'b0;
		lnk2.rd_n = rdl;
		cyc(1);
		chk_bit(lnk2.dev_d_oe, 1'b0, "drive in write");
		lnk2.wr_n = 1'b1;
		lnk2.rd_n = 1'b1;
		lnk2.host_d = 8'hff;
		lnk2.chip_select_active_low = 1'b0;
		cyc(APCP_BYTE_CYCLES + 4);
	endtask
	// Power-up timing, selection, write over read, status read, master mode
	task automatic t_side();
		int   tog;
		logic prev;
		rst2_n = 1'b1;
		cyc(T_INIT - 4);
		chk_bit(lnk2.init_n, 1'b0, "init early");
		cyc(10);
		chk_bit(lnk2.init_n, 1'b1, "init late");
		wr2(1'b1, 8'h3c, 1'b1);
		chk_byte(8'(n2), 8'h00, "unselected");
		wr2(1'b0, 8'hc3, 1'b0);
		chk_byte(8'(n2), 8'h01, "write over read");
		chk_byte(dbyte2, 8'hc3, "byte over read");
		lnk2.rd_n = 1'b0;
		cyc(2);
		chk_bit(lnk2.dev_d_oe, 1'b1, "status drive");
		chk_bit(lnk2.dev_d[7], 1'b1, "status ready");
		lnk2.rd_n = 1'b1;
		rst2_n = 1'b0;
		mode2 = APCP_MODE_MASTER_PAR;
		cyc(2);
		rst2_n = 1'b1;
		cyc(T_INIT + 8);
		tog = 0;
		prev = lnk2.ready;
		for (int c = 0; c < 16; c++) begin
			cyc(1);
			tog += int'(lnk2.ready !== prev);
			prev = lnk2.ready;
		end
		chk_bit(tog >= 3, 1'b1, "read clock");
		wr2(1'b0, 8'h5a, 1'b1);
		chk_byte(8'(n2), 8'h01, "master ignores write");
	endtask
	// Main sequence
	initial begin
		{rst_n_i, rst2_n, use_rd, byte_vld, scan_sel} = 5'h00;
		{hold_init, lnk2.wr_n, lnk2.rd_n, lnk2.chip_select_active_low} = 4'hf;
		byte_in = 8'h00;
		lnk2.host_d = 8'hff;
		mode2 = APCP_MODE_ASYNC_PERIPH;
		cyc(5);
		rst_n_i = 1'b1;
		t_init_hold();
		t_load();
		t_side();
		end_of_test();
	end
endmodule
`default_nettype wire
